// File: bench/port_side_model.sv
module port_side_model (
  input  logic       i_clk,
  input  logic [4:0] i_touch,
  output logic [4:0] o_port_access
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each touch becomes one bus strobe, so a fault count maps one to one.
  always_ff @(posedge i_clk) o_port_access <= i_touch;
endmodule

// File: bench/sleep_port_clock_gating_chk.sv
module sleep_port_clock_gating_chk (
  input logic        i_clk,
  input logic        i_rst,
  input logic        i_auto_clock_gating_enable,
  input logic        i_sleep,
  input logic        i_deep_sleep,
  input logic [4:0]  i_run_port_clock_gate,
  input logic [4:0]  i_deep_sleep_port_clock_gate,
  input logic [4:0]  i_port_access,
  input logic [4:0]  o_port_clock_enable,
  input logic [4:0]  o_port_access_fault,
  input logic        o_bus_fault,
  input logic [31:0] o_avs_readdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire [4:0] dark_hit = i_port_access & ~o_port_clock_enable;
  a_run_select: assert property (!i_auto_clock_gating_enable |=>
    o_port_clock_enable == $past(i_run_port_clock_gate)) else $error("run gate lost");
  a_deep_select: assert property (i_auto_clock_gating_enable && i_deep_sleep |=>
    o_port_clock_enable == $past(i_deep_sleep_port_clock_gate)) else $error("deep gate lost");
  a_awake_run: assert property (i_auto_clock_gating_enable && !i_deep_sleep && !i_sleep |=>
    o_port_clock_enable == $past(i_run_port_clock_gate)) else $error("awake gate lost");
  a_fault_pulse: assert property (|dark_hit |=>
    o_port_access_fault == $past(dark_hit) && o_bus_fault) else $error("no fault");
  a_clocked_quiet: assert property (!(|dark_hit) |=>
    o_port_access_fault == 5'h00) else $error("fault on clocked port");
  a_fault_or: assert property (o_bus_fault == |o_port_access_fault)
    else $error("bus fault mismatch");
  a_reset_clear: assert property (disable iff (1'b0) i_rst |=>
    o_port_clock_enable == 5'h00 && o_avs_readdata == 32'h0) else $error("reset");
  a_upper_zero: assert property (o_avs_readdata[31:5] == 27'h0)
    else $error("upper bits set");
endmodule
bind sleep_port_clock_gating sleep_port_clock_gating_chk i_chk (.*);

// File: bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 0, i_rst = 1, rd = 0, wr = 0, slp = 0, dsl = 0, auto_clock_gating_enable = 0;
  logic        wrq, bf, irq;
  logic [11:0] adr = 0;
  logic [31:0] wdat = 0, q, w, rdat;
  logic [4:0]  rg = 0, dg = 0, touch = 0, v, p, acc, en, pf;
  logic [1:0]  rsp, rsp_q;
  logic [3:0]  be = 4'hf;
  int          err_total = 0, n_compared = 0, seed = 32'h22f9, i;
  always #5 i_clk = ~i_clk;
  port_side_model i_far (.i_clk(i_clk), .i_touch(touch), .o_port_access(acc));
  sleep_port_clock_gating i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_waitrequest(wrq), .o_avs_readdata(rdat), .o_avs_response(rsp), .i_sleep(slp),
    .i_deep_sleep(dsl), .i_auto_clock_gating_enable(auto_clock_gating_enable), .i_run_port_clock_gate(rg),
    .i_deep_sleep_port_clock_gate(dg), .i_port_access(acc), .o_port_clock_enable(en),
    .o_port_access_fault(pf), .o_bus_fault(bf), .o_irq(irq));
  function automatic logic [4:0] dark(input logic [4:0] e, t);
    return t & ~e;
  endfunction
  task automatic cmp(input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic wt, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    adr <= a; wdat <= d; wr <= wt; rd <= !wt;
    n = 0;
    do begin @(posedge i_clk); n++; end while (wrq !== 1'b0 && n < 50);
    if (wrq !== 1'b0) begin
      err_total++;
      conclude();
    end
    q = rdat;
    rsp_q = rsp;
    rd <= 0; wr <= 0;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 0;
    bus(0, 12'h118, 0); cmp(0, q);
    cmp(2'h0, rsp_q);
    for (i = 0; i < 12; i++) begin
      w = $random(seed);
      if (i < 2) w = i ? 32'hffffffff : 32'h0;
      v = w[4:0];
      auto_clock_gating_enable <= 1; slp <= 1; dsl <= 0; rg <= $random(seed); dg <= $random(seed);
      bus(1, 12'h204, {32{i[0]}});
      bus(1, 12'h118, w);
      bus(0, 12'h118, 0); cmp(v, q);
      cmp(v, en);
      p = $random(seed);
      @(posedge i_clk) touch <= p;
      @(posedge i_clk) touch <= 0;
      repeat (2) @(posedge i_clk);
      cmp(|dark(v, p) & i[0], irq);
      bus(0, 12'h200, 0); cmp(dark(v, p), q);
      auto_clock_gating_enable <= $random(seed); slp <= $random(seed); dsl <= $random(seed);
      repeat (3) @(posedge i_clk);
    end
    be <= 4'he;
    bus(1, 12'h118, ~w);
    be <= 4'hf;
    bus(0, 12'h118, 0);
    cmp(v, q);
    bus(0, 12'h300, 0); cmp(2'h3, rsp_q);
    conclude();
  end
endmodule

// File: inc/sleep_port_clock_gating_defs.vh
`ifndef SLEEP_PORT_CLOCK_GATING_DEFS_VH
`define SLEEP_PORT_CLOCK_GATING_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SLEEP_PORT_CLOCK_GATE_OFS 12'h118
`define PORT_FAULT_STATUS_OFS     12'h200
`define PORT_FAULT_MASK_OFS       12'h204

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PORT_A_BIT                0
`define PORT_B_BIT                1
`define PORT_C_BIT                2
`define PORT_D_BIT                3
`define PORT_E_BIT                4
`define NUM_PORTS                 5
`define SLEEP_PORT_CLOCK_GATE_RST 5'h00
`define PORT_FAULT_STATUS_RST     5'h00
`define PORT_FAULT_MASK_RST       5'h00

// ----------------------------------------------------------------------------
// Avalon-MM response codes
// ----------------------------------------------------------------------------
`define AVS_RESP_OKAY             2'h0
`define AVS_RESP_DECODEERROR      2'h3

`endif

// File: rtl/sleep_port_clock_gating.v
// Added by the designer: the Avalon-MM register port.
`include "sleep_port_clock_gating_defs.vh"

module sleep_port_clock_gating (
  input  wire        i_clk,
  input  wire        i_rst,
  // Avalon-MM register slave.
  input  wire [11:0] i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire        o_avs_waitrequest,
  output wire [31:0] o_avs_readdata,
  output wire [1:0]  o_avs_response,
  // Power-mode state and companion gating registers, same clock domain.
  input  wire        i_sleep,
  input  wire        i_deep_sleep,
  input  wire        i_auto_clock_gating_enable,
  input  wire [4:0]  i_run_port_clock_gate,
  input  wire [4:0]  i_deep_sleep_port_clock_gate,
  // Per-port access strobes from the peripheral bus decoder.
  input  wire [4:0]  i_port_access,
  // Clock enables towards the port clock gates.
  output wire [4:0]  o_port_clock_enable,
  // One-cycle fault pulse per port and the bus fault to the processor.
  output wire [4:0]  o_port_access_fault,
  output wire        o_bus_fault,
  output wire        o_irq
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg         ack_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg  [1:0]  resp_q;
  reg  [1:0]  resp_d;
  reg         bus_fault_q;

  wire        req;
  wire        hit_gate;
  wire        hit_status;
  wire        hit_mask;
  wire        wr_lo;
  wire        wr_gate;
  wire        wr_mask;
  wire        rd_status;
  wire [4:0]  sleep_gate_q;
  wire [4:0]  fault_status_q;
  wire [4:0]  fault_mask_q;
  wire [4:0]  clk_en_q;
  wire [4:0]  fault_q;
  wire [4:0]  fault_d;

  // Reset images of the gating and interrupt registers, one bit per port.
  localparam [4:0] GATE_RST   = `SLEEP_PORT_CLOCK_GATE_RST;
  localparam [4:0] STATUS_RST = `PORT_FAULT_STATUS_RST;
  localparam [4:0] MASK_RST   = `PORT_FAULT_MASK_RST;

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  // Every access takes one wait cycle so that read data come from flip-flops.
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign o_avs_readdata    = rdata_q;
  assign o_avs_response    = resp_q;

  assign hit_gate   = (i_avs_address == `SLEEP_PORT_CLOCK_GATE_OFS);
  assign hit_status = (i_avs_address == `PORT_FAULT_STATUS_OFS);
  assign hit_mask   = (i_avs_address == `PORT_FAULT_MASK_OFS);
  assign wr_lo      = ack_q & i_avs_write & i_avs_byteenable[0];
  assign rd_status  = ack_q & i_avs_read & hit_status;

  always @* begin
    rdata_d = 32'h00000000;
    resp_d  = `AVS_RESP_OKAY;
    if (hit_gate) begin
      rdata_d[4:0] = sleep_gate_q;
    end else if (hit_status) begin
      rdata_d[4:0] = fault_status_q;
    end else if (hit_mask) begin
      rdata_d[4:0] = fault_mask_q;
    end else begin
      resp_d = `AVS_RESP_DECODEERROR;
    end
  end

  // The acknowledge toggles, so a request still held after its accepting
  // edge is taken as a fresh access rather than answered twice at once.
  always @(posedge i_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data stand only in the accepting cycle and are zero otherwise.
  always @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h00000000;
    end else if (req & ~ack_q & i_avs_read) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      resp_q <= `AVS_RESP_OKAY;
    end else if (req & ~ack_q) begin
      resp_q <= resp_d;
    end else begin
      resp_q <= `AVS_RESP_OKAY;
    end
  end

  // --------------------------------------------------------------------------
  // Register write strobes
  // --------------------------------------------------------------------------
  // Writes act only on the accepting edge, so a master that holds its request
  // through the wait cycle sees each access take effect exactly once.
  assign wr_gate = wr_lo & hit_gate;
  assign wr_mask = wr_lo & hit_mask;

  // --------------------------------------------------------------------------
  // Per-port gating, fault and interrupt state
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g = g + 1) begin : g_port
      // Field position of this port's enable in the register word.
      localparam integer POS = (g == 0) ? `PORT_A_BIT :
                               (g == 1) ? `PORT_B_BIT :
                               (g == 2) ? `PORT_C_BIT :
                               (g == 3) ? `PORT_D_BIT :
                                          `PORT_E_BIT;

      reg  gate_q;
      reg  mask_q;
      reg  status_q;
      reg  status_d;
      reg  en_q;
      reg  en_d;
      reg  fault_bit_q;
      wire dark_hit;

      // ----------------------------------------------------------------------
      // Sleep gating enable
      // ----------------------------------------------------------------------
      always @(posedge i_clk) begin
        if (i_rst) begin
          gate_q <= GATE_RST[POS];
        end else if (wr_gate) begin
          gate_q <= i_avs_writedata[POS];
        end
      end

      assign sleep_gate_q[POS] = gate_q;

      // ----------------------------------------------------------------------
      // Fault mask
      // ----------------------------------------------------------------------
      always @(posedge i_clk) begin
        if (i_rst) begin
          mask_q <= MASK_RST[POS];
        end else if (wr_mask) begin
          mask_q <= i_avs_writedata[POS];
        end
      end

      assign fault_mask_q[POS] = mask_q;

      // ----------------------------------------------------------------------
      // Sticky fault status
      // ----------------------------------------------------------------------
      // The clear drops only what the read returned, and a new fault wins over
      // it; a fault that lands inside the wait cycle is therefore never lost.
      always @* begin
        status_d = status_q | dark_hit;
        if (rd_status) begin
          status_d = (status_q & ~rdata_q[POS]) | dark_hit;
        end
      end

      always @(posedge i_clk) begin
        if (i_rst) begin
          status_q <= STATUS_RST[POS];
        end else begin
          status_q <= status_d;
        end
      end

      assign fault_status_q[POS] = status_q;

      // ----------------------------------------------------------------------
      // Clock enable selection
      // ----------------------------------------------------------------------
      // Without automatic gating the run register stays in force in every mode.
      always @* begin
        en_d = i_run_port_clock_gate[POS];
        if (i_auto_clock_gating_enable) begin
          if (i_deep_sleep) begin
            en_d = i_deep_sleep_port_clock_gate[POS];
          end else if (i_sleep) begin
            en_d = gate_q;
          end
        end
      end

      always @(posedge i_clk) begin
        if (i_rst) begin
          en_q <= 1'b0;
        end else begin
          en_q <= en_d;
        end
      end

      assign clk_en_q[POS] = en_q;

      // ----------------------------------------------------------------------
      // Access to an unclocked port
      // ----------------------------------------------------------------------
      // The check uses the enable the port really has in this cycle, so a
      // change of power mode cannot hide an access that raced it.
      assign dark_hit = i_port_access[POS] & ~en_q;

      always @(posedge i_clk) begin
        if (i_rst) begin
          fault_bit_q <= 1'b0;
        end else begin
          fault_bit_q <= dark_hit;
        end
      end

      assign fault_q[POS] = fault_bit_q;
      assign fault_d[POS] = dark_hit;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Bus fault and interrupt
  // --------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      bus_fault_q <= 1'b0;
    end else begin
      bus_fault_q <= |fault_d;
    end
  end

  assign o_irq = |(fault_status_q & fault_mask_q);

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_port_clock_enable = clk_en_q;
  assign o_port_access_fault = fault_q;
  assign o_bus_fault         = bus_fault_q;

endmodule
